// ---- slc_defines.vh ----
// Constants for the sleep controller: mode codes, wake and clock counts.
// Assumes inclusion by bare name from the sleep controller design file.
// How it works
// - Forced oscillator stays powered in every mode
// - Gate opens after four cycles of synchronised request
// - Forced oscillator output gated without request
// - One active mode, three sleep modes
// - Sleep halts CPU; wake on irq/reset/break
// - Interrupt wake runs handler, then resumes
// - Reset in sleep restarts from reset vector
// - Register, SRAM, peripheral contents kept
// - Debug break wakes regardless of interrupts
// - No enabled interrupt: only reset or debug break wakes
// - Idle stops CPU clock, all irqs wake
// - Standby wakes: pin, TWI, TCB, PIT always; SOF, RTC, ADCW by run bits
// - Standby RTC/ADC alive only with run bit; watchdog, PIT always
// - ADC sleepwalks in standby without waking CPU
// - Power-down keeps watchdog, periodic timer only
// - Controller clocked by peripheral clock
// - Mode codes: idle 0, standby 1, power-down 2
// - Wake takes six cycles plus oscillator start
// - Brown-out code 3 extends wake until ready
`ifndef SLC_DEFINES_VH
`define SLC_DEFINES_VH
`define SLC_MODE_IDLE 2'h0
`define SLC_MODE_STANDBY 2'h1
`define SLC_MODE_POWER_DOWN_MODE 2'h2
`define SLC_BOD_WAIT_CODE 2'h3
`define SLC_WAKE_CYCLES 4'h6
`define SLC_GATE_CYCLES 3'h4
`define SLC_OSC_START_NS 32'd1000
`define SLC_CLK_PERIOD_NS 32'd40
`define SLC_WAKE_SRC_PIN 0
`define SLC_WAKE_SRC_TWI 1
`define SLC_WAKE_SRC_TCB 2
`define SLC_WAKE_SRC_SOF 3
`define SLC_WAKE_SRC_RTC 4
`define SLC_WAKE_SRC_ADCW 5
`define SLC_WAKE_SRC_PIT 6
`define SLC_WAKE_SRC_OTHER 7
`endif

// ---- slc_sleep_controller.v ----
// Sleep controller: mode entry, clock and oscillator enables, wake timing.
// Assumes a clock controller supplies SYS_CLK_IN as the peripheral clock
// and any system reset drives ARST_N_IN low.
`timescale 1ns/100ps
`default_nettype none
`include "slc_defines.vh"
module slc_sleep_controller (
   input wire SYS_CLK_IN,
   input wire ARST_N_IN,
   input wire SLEEP_ENABLE_IN,
   input wire [1:0] SLEEP_MODE_SELECT_IN,
   input wire SLEEP_INSTR_IN,
   input wire [7:0] IRQ_PENDING_IN,
   input wire [7:0] IRQ_ENABLE_IN,
   input wire GLOBAL_IRQ_ENABLE_IN,
   input wire DEBUG_BREAK_IN,
   input wire RTC_RUN_IN_STANDBY_IN,
   input wire ADC_RUN_IN_STANDBY_IN,
   input wire USART_RUN_IN_STANDBY_IN,
   input wire MAIN_OSC_FORCE_ON_IN,
   input wire RTC_OSC_FORCE_ON_IN,
   input wire MAIN_CLK_REQUEST_IN,
   input wire RTC_CLK_REQUEST_IN,
   input wire [1:0] BOD_ACTIVE_CFG_IN,
   input wire BOD_READY_IN,
   output reg CPU_HALT_OUT,
   output reg CPU_CLK_EN_OUT,
   output reg PERIPH_CLK_EN_OUT,
   output reg RTC_CLK_EN_OUT,
   output reg ADC_CLK_EN_OUT,
   output reg PIT_CLK_EN_OUT,
   output reg WDT_CLK_EN_OUT,
   output reg MAIN_OSC_POWER_OUT,
   output reg RTC_OSC_POWER_OUT,
   output reg WDT_OSC_POWER_OUT,
   output reg MAIN_CLK_GATE_OUT,
   output reg RTC_CLK_GATE_OUT,
   output reg WAKE_IRQ_OUT,
   output reg ASLEEP_OUT,
   output reg [1:0] SLEEP_STATE_OUT
);

   localparam [3:0] ST_ACTIVE = 4'h1;
   localparam [3:0] ST_SLEEP = 4'h2;
   localparam [3:0] ST_OSC = 4'h4;
   localparam [3:0] ST_WAKE = 4'h8;
   localparam [31:0] OSC_START_CYC =
      (`SLC_OSC_START_NS + `SLC_CLK_PERIOD_NS - 32'd1) / `SLC_CLK_PERIOD_NS;

   // Two-flop synchronisers for the asynchronous wake and status inputs
   wire [10:0] async_raw;
   reg [10:0] sync1_reg;
   reg [10:0] sync2_reg;
   assign async_raw = {BOD_READY_IN, DEBUG_BREAK_IN, IRQ_PENDING_IN,
                       MAIN_CLK_REQUEST_IN};
   always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sync1_reg <= 11'h000;
         sync2_reg <= 11'h000;
      end else begin
         sync1_reg <= async_raw;
         sync2_reg <= sync1_reg;
      end
   end
   wire bod_ready_s = sync2_reg[10];
   wire dbg_break_s = sync2_reg[9];
   wire [7:0] irq_s = sync2_reg[8:1];
   wire main_req_s = sync2_reg[0];

   // Which wake sources are honoured in a given mode
   function [7:0] wake_mask;
      input [1:0] mode;
      input rtc_rs;
      input adc_rs;
      input usart_rs;
      begin
         wake_mask = 8'h00;
         case (mode)
            `SLC_MODE_IDLE: wake_mask = 8'hff;
            `SLC_MODE_STANDBY: begin
               wake_mask[`SLC_WAKE_SRC_PIN] = 1'b1;
               wake_mask[`SLC_WAKE_SRC_TWI] = 1'b1;
               wake_mask[`SLC_WAKE_SRC_TCB] = 1'b1;
               wake_mask[`SLC_WAKE_SRC_PIT] = 1'b1;
               wake_mask[`SLC_WAKE_SRC_SOF] = usart_rs;
               wake_mask[`SLC_WAKE_SRC_RTC] = rtc_rs;
               wake_mask[`SLC_WAKE_SRC_ADCW] = adc_rs;
            end
            `SLC_MODE_POWER_DOWN_MODE: begin
               wake_mask[`SLC_WAKE_SRC_PIN] = 1'b1;
               wake_mask[`SLC_WAKE_SRC_TWI] = 1'b1;
            end
            default: wake_mask = 8'h00;
         endcase
      end
   endfunction

   // Clock domain alive while asleep: always in idle, by run bit in standby
   function domain_on;
      input asleep;
      input [1:0] mode;
      input run_bit;
      begin
         domain_on = !asleep || (mode == `SLC_MODE_IDLE) ||
            ((mode == `SLC_MODE_STANDBY) && run_bit);
      end
   endfunction

   // Main oscillator kept while asleep: idle, forced on, or a standby user
   function main_osc_kept;
      input [1:0] mode;
      input force_on;
      input rtc_rs;
      input adc_rs;
      begin
         case (mode)
            `SLC_MODE_IDLE: main_osc_kept = 1'b1;
            `SLC_MODE_STANDBY: main_osc_kept = force_on || rtc_rs || adc_rs;
            default: main_osc_kept = force_on;
         endcase
      end
   endfunction

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [1:0] mode_reg;
   reg [1:0] mode_next;
   reg [31:0] cnt_reg;
   reg [31:0] cnt_next;
   reg main_was_off_reg;
   reg main_was_off_next;

   wire mode_ok = (SLEEP_MODE_SELECT_IN == `SLC_MODE_IDLE) ||
                  (SLEEP_MODE_SELECT_IN == `SLC_MODE_STANDBY) ||
                  (SLEEP_MODE_SELECT_IN == `SLC_MODE_POWER_DOWN_MODE);
   wire [7:0] wake_hits = irq_s & IRQ_ENABLE_IN &
      wake_mask(mode_reg, RTC_RUN_IN_STANDBY_IN, ADC_RUN_IN_STANDBY_IN,
                USART_RUN_IN_STANDBY_IN);
   // Without global enable no interrupt can wake; only reset or a debug break then helps
   wire irq_wake = GLOBAL_IRQ_ENABLE_IN && (|wake_hits);
   wire bod_wait = (BOD_ACTIVE_CFG_IN == `SLC_BOD_WAIT_CODE);
   // A forced-on oscillator needs no start-up wait, even in power-down
   wire main_alive_sleep = main_osc_kept(mode_reg, MAIN_OSC_FORCE_ON_IN,
      RTC_RUN_IN_STANDBY_IN, ADC_RUN_IN_STANDBY_IN);

   always @* begin
      state_next = state_reg;
      mode_next = mode_reg;
      cnt_next = cnt_reg;
      main_was_off_next = main_was_off_reg;
      case (state_reg)
         ST_ACTIVE: begin
            // Sleep with enable clear, or a reserved code, acts as a no-op
            if (SLEEP_INSTR_IN && SLEEP_ENABLE_IN && mode_ok) begin
               state_next = ST_SLEEP;
               mode_next = SLEEP_MODE_SELECT_IN;
            end
         end
         ST_SLEEP: begin
            if (irq_wake || dbg_break_s) begin
               main_was_off_next = !main_alive_sleep;
               if (!main_alive_sleep) begin
                  state_next = ST_OSC;
                  cnt_next = OSC_START_CYC;
               end else begin
                  state_next = ST_WAKE;
                  cnt_next = {28'h0000000, `SLC_WAKE_CYCLES};
               end
            end
         end
         ST_OSC: begin
            if (cnt_reg <= 32'd1) begin
               state_next = ST_WAKE;
               cnt_next = {28'h0000000, `SLC_WAKE_CYCLES};
            end else begin
               cnt_next = cnt_reg - 32'd1;
            end
         end
         ST_WAKE: begin
            if (cnt_reg > 32'd1) begin
               cnt_next = cnt_reg - 32'd1;
            end else if (!bod_wait || bod_ready_s) begin
               state_next = ST_ACTIVE;
               cnt_next = 32'd0;
            end
         end
         default: state_next = ST_ACTIVE;
      endcase
   end

   always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_reg <= ST_ACTIVE;
         mode_reg <= `SLC_MODE_IDLE;
         cnt_reg <= 32'd0;
         main_was_off_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         cnt_reg <= cnt_next;
         main_was_off_reg <= main_was_off_next;
      end
   end

   // Clock gates: four cycles of continuous request before opening
   reg [1:0] rtc_req_sync_reg;
   wire sleeping = (state_reg == ST_SLEEP) || (state_reg == ST_OSC);
   wire main_osc_on = MAIN_OSC_FORCE_ON_IN || !sleeping ||
                      main_alive_sleep;
   wire rtc_osc_on = RTC_OSC_FORCE_ON_IN ||
      domain_on(sleeping, mode_reg, RTC_RUN_IN_STANDBY_IN);
   wire [1:0] gate_req;
   wire [1:0] gate_osc_on;
   wire [5:0] gate_cnt;
   assign gate_req = {rtc_req_sync_reg[1], main_req_s};
   assign gate_osc_on = {rtc_osc_on, main_osc_on};
   always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rtc_req_sync_reg <= 2'h0;
      end else begin
         rtc_req_sync_reg <= {rtc_req_sync_reg[0], RTC_CLK_REQUEST_IN};
      end
   end
   // No request, no output, even with the oscillator forced on
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_gate
         reg [2:0] cnt_reg;
         always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
               cnt_reg <= 3'h0;
            end else if (!gate_req[g] || !gate_osc_on[g]) begin
               cnt_reg <= 3'h0;
            end else if (cnt_reg != `SLC_GATE_CYCLES) begin
               cnt_reg <= cnt_reg + 3'h1;
            end
         end
         assign gate_cnt[3*g+2:3*g] = cnt_reg;
      end
   endgenerate

   reg cpu_halt_next;
   reg cpu_clk_en_next;
   reg periph_clk_en_next;
   reg rtc_clk_en_next;
   reg adc_clk_en_next;
   reg pit_clk_en_next;
   reg wdt_clk_en_next;
   reg main_osc_power_next;
   reg rtc_osc_power_next;
   reg wdt_osc_power_next;
   reg main_clk_gate_next;
   reg rtc_clk_gate_next;
   reg wake_irq_next;
   reg asleep_next;
   reg [1:0] sleep_state_next;

   // Next values of the registered outputs
   always @* begin
      cpu_halt_next = 1'b1;
      cpu_clk_en_next = 1'b0;
      asleep_next = 1'b1;
      case (state_next)
         ST_ACTIVE: begin
            cpu_halt_next = 1'b0;
            cpu_clk_en_next = 1'b1;
            asleep_next = 1'b0;
         end
         default: begin
            cpu_halt_next = 1'b1;
            cpu_clk_en_next = 1'b0;
            asleep_next = 1'b1;
         end
      endcase
      periph_clk_en_next = domain_on(sleeping, mode_reg, 1'b0);
      rtc_clk_en_next = domain_on(sleeping, mode_reg, RTC_RUN_IN_STANDBY_IN);
      // ADC keeps its clock for sleepwalking; CPU stays halted
      adc_clk_en_next = domain_on(sleeping, mode_reg,
                                  ADC_RUN_IN_STANDBY_IN);
      // Watchdog, periodic timer and their oscillator never stop
      pit_clk_en_next = 1'b1;
      wdt_clk_en_next = 1'b1;
      wdt_osc_power_next = 1'b1;
      main_osc_power_next = main_osc_on;
      rtc_osc_power_next = rtc_osc_on;
      main_clk_gate_next = (gate_cnt[2:0] == `SLC_GATE_CYCLES);
      rtc_clk_gate_next = (gate_cnt[5:3] == `SLC_GATE_CYCLES);
      // Pulse on return so the handler runs before the next instruction
      wake_irq_next = (state_reg == ST_WAKE) &&
                      (state_next == ST_ACTIVE) && !dbg_break_s;
      sleep_state_next = mode_next;
   end

   // Registered outputs; clock gating only, so state is never lost
   always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         CPU_HALT_OUT <= 1'b0;
         CPU_CLK_EN_OUT <= 1'b1;
         PERIPH_CLK_EN_OUT <= 1'b1;
         RTC_CLK_EN_OUT <= 1'b1;
         ADC_CLK_EN_OUT <= 1'b1;
         PIT_CLK_EN_OUT <= 1'b1;
         WDT_CLK_EN_OUT <= 1'b1;
         MAIN_OSC_POWER_OUT <= 1'b1;
         RTC_OSC_POWER_OUT <= 1'b1;
         WDT_OSC_POWER_OUT <= 1'b1;
         MAIN_CLK_GATE_OUT <= 1'b0;
         RTC_CLK_GATE_OUT <= 1'b0;
         WAKE_IRQ_OUT <= 1'b0;
         ASLEEP_OUT <= 1'b0;
         SLEEP_STATE_OUT <= 2'h0;
      end else begin
         CPU_HALT_OUT <= cpu_halt_next;
         CPU_CLK_EN_OUT <= cpu_clk_en_next;
         PERIPH_CLK_EN_OUT <= periph_clk_en_next;
         RTC_CLK_EN_OUT <= rtc_clk_en_next;
         ADC_CLK_EN_OUT <= adc_clk_en_next;
         PIT_CLK_EN_OUT <= pit_clk_en_next;
         WDT_CLK_EN_OUT <= wdt_clk_en_next;
         MAIN_OSC_POWER_OUT <= main_osc_power_next;
         RTC_OSC_POWER_OUT <= rtc_osc_power_next;
         WDT_OSC_POWER_OUT <= wdt_osc_power_next;
         MAIN_CLK_GATE_OUT <= main_clk_gate_next;
         RTC_CLK_GATE_OUT <= rtc_clk_gate_next;
         WAKE_IRQ_OUT <= wake_irq_next;
         ASLEEP_OUT <= asleep_next;
         SLEEP_STATE_OUT <= sleep_state_next;
      end
   end

endmodule // slc_sleep_controller
`default_nettype wire

// ---- slc_sleep_checker.sv ----
// Port-level checks for the sleep controller.
// Assumes binding onto slc_sleep_controller, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module slc_sleep_checker (
   input wire logic SYS_CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic SLEEP_ENABLE_IN,
   input wire logic [1:0] SLEEP_MODE_SELECT_IN,
   input wire logic SLEEP_INSTR_IN,
   input wire logic MAIN_OSC_FORCE_ON_IN,
   input wire logic MAIN_CLK_REQUEST_IN,
   input wire logic CPU_HALT_OUT,
   input wire logic CPU_CLK_EN_OUT,
   input wire logic PERIPH_CLK_EN_OUT,
   input wire logic ADC_CLK_EN_OUT,
   input wire logic PIT_CLK_EN_OUT,
   input wire logic WDT_CLK_EN_OUT,
   input wire logic MAIN_OSC_POWER_OUT,
   input wire logic WDT_OSC_POWER_OUT,
   input wire logic MAIN_CLK_GATE_OUT,
   input wire logic WAKE_IRQ_OUT,
   input wire logic ASLEEP_OUT,
   input wire logic [1:0] SLEEP_STATE_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   wire take = SLEEP_INSTR_IN && SLEEP_ENABLE_IN && !ASLEEP_OUT
      && SLEEP_MODE_SELECT_IN != 2'h3;
   halt_on_sleep_a: assert property (
      take |=> ASLEEP_OUT && CPU_HALT_OUT && !CPU_CLK_EN_OUT
      && SLEEP_STATE_OUT == $past(SLEEP_MODE_SELECT_IN)) else $error("no sleep");
   skip_sleep_a: assert property (
      !ASLEEP_OUT && SLEEP_INSTR_IN && (!SLEEP_ENABLE_IN
      || SLEEP_MODE_SELECT_IN == 2'h3) |=> !ASLEEP_OUT) else $error("slept");
   idle_clocks_a: assert property (
      ASLEEP_OUT && SLEEP_STATE_OUT == 2'h0 |-> PERIPH_CLK_EN_OUT
      && ADC_CLK_EN_OUT && !CPU_CLK_EN_OUT) else $error("idle clocks");
   always_on_a: assert property (
      WDT_CLK_EN_OUT && PIT_CLK_EN_OUT && WDT_OSC_POWER_OUT)
      else $error("watchdog domain off");
   force_on_a: assert property (
      MAIN_OSC_FORCE_ON_IN [*3] |-> MAIN_OSC_POWER_OUT) else $error("osc off");
   gate_closed_a: assert property (
      !MAIN_CLK_REQUEST_IN [*5] |-> !MAIN_CLK_GATE_OUT) else $error("gate open");
   gate_open_a: assert property (
      $rose(MAIN_CLK_GATE_OUT) |-> $past(MAIN_CLK_REQUEST_IN, 4)
      && MAIN_OSC_POWER_OUT) else $error("gate early");
   wake_pulse_a: assert property (
      WAKE_IRQ_OUT |-> !CPU_HALT_OUT ##1 !WAKE_IRQ_OUT) else $error("pulse");
   wake_time_a: assert property (
      $fell(CPU_HALT_OUT) |-> $past(CPU_HALT_OUT, 6)) else $error("wake fast");
endmodule // slc_sleep_checker
bind slc_sleep_controller slc_sleep_checker u_chk (.*);
`default_nettype wire

// ---- slc_cpu_model.sv ----
// CPU side: issues sleep instructions and counts handler entries.
// Assumes the sleep controller's clock.
`timescale 1ns/100ps
`default_nettype none
module slc_cpu_model (
   input wire logic clk_in,
   input wire logic sleep_req_in,
   input wire logic halt_in,
   input wire logic wake_irq_in,
   output logic sleep_instr_out,
   output logic [7:0] isr_count_out
);
   initial begin
      sleep_instr_out = 1'b0;
      isr_count_out = 8'h00;
   end
   // Sleep only while executing; enables are set up before the request
   always @(posedge clk_in) begin
      sleep_instr_out <= sleep_req_in && !halt_in && !sleep_instr_out;
      if (wake_irq_in) begin
         isr_count_out <= isr_count_out + 8'h01;
      end
   end
endmodule // slc_cpu_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the sleep controller and CPU model.
// Assumes a 25 MHz clock; slow paths are bounded by polling limits.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, sleep_enable = 1'b0, req = 1'b0, gie = 1'b1;
   logic dbg = 1'b0, brdy = 1'b1, mf = 1'b0, mreq = 1'b0, rr = 1'b0;
   logic [1:0] mode = 2'h0, brown_out_detector = 2'h0;
   logic [7:0] irq = 8'h00, ien = 8'hff;
   wire slp, halt, wirq, asl, mpow, mgate;
   wire [7:0] isr;
   int n_mismatch = 0, total_checks = 0;
   int lat = 0;
   // Fields: mode, rtc run bit, wakes, source
   logic [11:0] tbl [7] = '{12'h180, 12'h501, 12'h504, 12'h410, 12'h710,
      12'h902, 12'h804};
   slc_sleep_controller dut (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n),
      .SLEEP_ENABLE_IN(sleep_enable), .SLEEP_MODE_SELECT_IN(mode),
      .SLEEP_INSTR_IN(slp), .IRQ_PENDING_IN(irq), .IRQ_ENABLE_IN(ien),
      .GLOBAL_IRQ_ENABLE_IN(gie), .DEBUG_BREAK_IN(dbg),
      .RTC_RUN_IN_STANDBY_IN(rr), .ADC_RUN_IN_STANDBY_IN(1'b0),
      .USART_RUN_IN_STANDBY_IN(1'b0), .MAIN_OSC_FORCE_ON_IN(mf),
      .RTC_OSC_FORCE_ON_IN(1'b0), .MAIN_CLK_REQUEST_IN(mreq),
      .RTC_CLK_REQUEST_IN(1'b0), .BOD_ACTIVE_CFG_IN(brown_out_detector),
      .BOD_READY_IN(brdy), .CPU_HALT_OUT(halt), .CPU_CLK_EN_OUT(),
      .PERIPH_CLK_EN_OUT(), .RTC_CLK_EN_OUT(), .ADC_CLK_EN_OUT(),
      .PIT_CLK_EN_OUT(), .WDT_CLK_EN_OUT(), .MAIN_OSC_POWER_OUT(mpow),
      .RTC_OSC_POWER_OUT(), .WDT_OSC_POWER_OUT(), .MAIN_CLK_GATE_OUT(mgate),
      .RTC_CLK_GATE_OUT(), .WAKE_IRQ_OUT(wirq), .ASLEEP_OUT(asl),
      .SLEEP_STATE_OUT());
   slc_cpu_model cpu (.clk_in(clk), .sleep_req_in(req), .halt_in(halt),
      .wake_irq_in(wirq), .sleep_instr_out(slp), .isr_count_out(isr));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Checks sit on falling edges so the design's updates have landed
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic go_sleep(input logic [1:0] m, input logic e);
      @(posedge clk);
      mode <= m;
      sleep_enable <= e;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      tick(3);
   endtask
   // Unwoken sleep is ended by a debug break, which must not run a handler
   task automatic wake(input logic [7:0] src, input logic w);
      logic [7:0] c0;
      c0 = isr;
      @(posedge clk);
      irq <= src;
      for (lat = 0; lat < 60 && halt !== 1'b0; lat++) @(negedge clk);
      chk({7'h0, halt}, {7'h0, !w});
      @(posedge clk);
      irq <= 8'h00;
      dbg <= halt;
      for (int n = 0; n < 40 && halt !== 1'b0; n++) @(negedge clk);
      @(posedge clk);
      dbg <= 1'b0;
      tick(2);
      chk({7'h0, halt}, 8'h00);
      chk(isr - c0, {7'h0, w});
   endtask
   task automatic t_noirq;
      @(posedge clk);
      ien <= 8'h00;
      go_sleep(2'h0, 1'b1);
      @(posedge clk);
      irq <= 8'hff;
      tick(50);
      chk({7'h0, asl}, 8'h01);
      @(posedge clk);
      rst_n <= 1'b0;
      irq <= 8'h00;
      ien <= 8'hff;
      @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      chk({6'h0, asl, halt}, 8'h00);
   endtask
   task automatic t_bod;
      @(posedge clk);
      brown_out_detector <= 2'h3;
      brdy <= 1'b0;
      go_sleep(2'h0, 1'b1);
      @(posedge clk);
      irq <= 8'h80;
      tick(40);
      chk({7'h0, halt}, 8'h01);
      @(posedge clk);
      brdy <= 1'b1;
      wake(8'h80, 1'b1);
      @(posedge clk);
      brown_out_detector <= 2'h0;
   endtask
   task automatic t_gate;
      @(posedge clk);
      mf <= 1'b1;
      go_sleep(2'h2, 1'b1);
      tick(5);
      chk({6'h0, mpow, mgate}, 8'h02);
      wake(8'h01, 1'b1);
      // Forced oscillator: two sync cycles, entry, six wake cycles only
      chk(lat[7:0], 8'h0a);
      @(posedge clk);
      mreq <= 1'b1;
      tick(12);
      chk({7'h0, mgate}, 8'h01);
      @(posedge clk);
      mreq <= 1'b0;
      mf <= 1'b0;
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      tick(5);
      @(posedge clk);
      rst_n <= 1'b1;
      tick(1);
      chk({6'h0, asl, halt}, 8'h00);
      go_sleep(2'h0, 1'b0);
      chk({7'h0, asl}, 8'h00);
      go_sleep(2'h3, 1'b1);
      chk({7'h0, asl}, 8'h00);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         rr <= tbl[i][9];
         go_sleep(tbl[i][11:10], 1'b1);
         chk({7'h0, asl}, 8'h01);
         wake(tbl[i][7:0], tbl[i][8]);
      end
      t_noirq;
      t_bod;
      t_gate;
      wrap_up;
   end
   initial begin
      tick(4000);
      n_mismatch++;
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
